// file: switch_diag.sv
// Power switch offline and online diagnostics with AXI4-Lite registers
//
// Overview of operation
// - Rectifier offline check on contactor close, start and reset commands.
// - Rectifier check runs passive then active stage; passive gates nothing.
// - Thyristor passive: feedback must toggle each line cycle, else short.
// - PWM passive: low feedback marks switch failed, steering active gating.
// - Thyristor active: gate each switch at peak, compare feedback around it.
// - Thyristor active: high before and after gating raises open fault.
// - Thyristor active: low before and after gating raises short fault.
// - PWM active: gate at peak, skip switches risking line-to-line short.
// - PWM active: failed before/after pattern raises device fault.
// - PWM active: no light before and after raises feedback fibre loss.
// - PWM active: light before and after raises gating fibre loss.
// - Enough failed switches for a line short inhibit contactor closing.
// - Inverter offline check at power-up, start and reset commands.
// - Inverter check is PWM active check without passive, peak wait, skip or interlock.
// - Thyristor online: all pre-fire samples on advance short timer.
// - Short fault once count exceeds rectifier delay; zero faults at once.
// - Thyristor online: not on after firing, open fault after 6 counts.
// - Thyristor online checks suspended below 15 degrees or discontinuous.
// - Gate-commutated online: bad pre and post samples advance device timer.
// - Those timers count bridge changes, with rectifier or inverter delay.
// - Online monitoring only while gating is enabled for both converters.
`timescale 1ns/1ps
`default_nettype none
`include "switch_diag_map.svh"
module switch_diag #(
	parameter int N = 6
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [N-1:0] rect_fbk,
	input wire logic [N-1:0] inv_fbk,
	input wire logic [N-1:0] rect_run_gate,
	input wire logic [N-1:0] inv_run_gate,
	output logic [N-1:0] rect_gate,
	output logic [N-1:0] inv_gate,
	input wire logic gating_on,
	input wire logic contactor_closed,
	input wire logic line_tick,
	input wire logic volt_peak,
	input wire logic alpha_low,
	input wire logic dc_discont,
	input wire logic thy_sample,
	input wire logic thy_fire,
	input wire logic thy_check,
	input wire logic [$clog2(N)-1:0] thy_idx,
	input wire logic rect_bridge_pre,
	input wire logic rect_bridge_post,
	input wire logic inv_bridge_pre,
	input wire logic inv_bridge_post,
	output logic contactor_inhibit,
	output logic diag_busy
);
	localparam int IW = $clog2(N);
	localparam int P = N / 2;
	localparam int TW = 9;

	typedef struct packed {
		switch_diag_pkg::seq_state_t st;
		logic conv;
		logic rect_req;
		logic inv_req;
		logic [IW-1:0] idx;
		logic [15:0] tmr;
		logic [3:0] lcnt;
		logic pre;
		logic [N-1:0] fbk_prev;
		logic [N-1:0] toggled;
		logic [N-1:0] failed;
		logic [N-1:0] rect_gate;
		logic [N-1:0] inv_gate;
		logic [N-1:0] ro_short;
		logic [N-1:0] ro_open;
		logic [N-1:0] r_dev;
		logic [N-1:0] r_fbk;
		logic [N-1:0] r_gat;
		logic [N-1:0] rn_short;
		logic [N-1:0] rn_open;
		logic [N-1:0] rn_dev;
		logic [N-1:0] i_dev;
		logic [N-1:0] i_fbk;
		logic [N-1:0] i_gat;
		logic [N-1:0] in_dev;
		logic [N-1:0] rmal_pre;
		logic [N-1:0] imal_pre;
		logic inhibit;
		logic cont_prev;
		logic thy_all;
		logic thy_seen;
		logic rect_pwm;
		logic [7:0] rdly;
		logic [7:0] idly;
		logic aw_ok;
		logic w_ok;
		logic [7:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} diag_state_t;

	diag_state_t q;
	diag_state_t d;

	logic [N-1:0] sh_step, sh_ok, sh_hit;
	logic [N-1:0] op_step, op_ok, op_hit;
	logic [N-1:0] rd_step, rd_ok, rd_hit;
	logic [N-1:0] id_step, id_ok, id_hit;
	logic [N-1:0] rect_mal, inv_mal;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// True when some failed upper and lower switches sit in different phases
	function automatic logic line_short(input logic [N-1:0] bad);
		logic r;
		r = 1'b0;
		for (int a = 0; a < P; a++) begin
			for (int b = 0; b < P; b++) begin
				if (a != b && bad[a] && bad[P + b]) begin
					r = 1'b1;
				end
			end
		end
		return r;
	endfunction : line_short

	// True when gating this switch could short two lines through a failure
	function automatic logic unsafe(input logic [IW-1:0] i,
			input logic [N-1:0] bad);
		logic r;
		r = 1'b0;
		for (int j = 0; j < N; j++) begin
			if (bad[j] && ((int'(i) < P) != (j < P)) &&
					(int'(i) % P != j % P)) begin
				r = 1'b1;
			end
		end
		return r;
	endfunction : unsafe

	function automatic logic [31:0] lanes(input logic [N-1:0] a,
			input logic [N-1:0] b, input logic [N-1:0] c,
			input logic [N-1:0] e);
		return {8'(a), 8'(b), 8'(c), 8'(e)};
	endfunction : lanes

	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int k = 0; k < 4; k++) begin
			if (strb[k]) begin
				r[k*8 +: 8] = nw[k*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	////////////////////////////////////////////////////////////////////////
	// Persistence timers, one set per switch

	assign rect_mal = rect_fbk ^ rect_run_gate;
	assign inv_mal = inv_fbk ^ inv_run_gate;

	for (genvar g = 0; g < N; g++) begin : g_sw
		persist_if #(.W(TW)) t_sh ();
		persist_if #(.W(TW)) t_op ();
		persist_if #(.W(TW)) t_rd ();
		persist_if #(.W(TW)) t_id ();
		assign t_sh.step = sh_step[g];
		assign t_sh.healthy = sh_ok[g];
		assign t_sh.limit = {1'b0, q.rdly} + TW'(1);
		assign sh_hit[g] = t_sh.hit;
		assign t_op.step = op_step[g];
		assign t_op.healthy = op_ok[g];
		assign t_op.limit = `OPEN_FAULT_COUNT;
		assign op_hit[g] = t_op.hit;
		assign t_rd.step = rd_step[g];
		assign t_rd.healthy = rd_ok[g];
		assign t_rd.limit = {1'b0, q.rdly};
		assign rd_hit[g] = t_rd.hit;
		assign t_id.step = id_step[g];
		assign t_id.healthy = id_ok[g];
		assign t_id.limit = {1'b0, q.idly};
		assign id_hit[g] = t_id.hit;
		persist_timer #(.W(TW)) u_sh (.aclk(aclk), .aresetn(aresetn),
			.t(t_sh));
		persist_timer #(.W(TW)) u_op (.aclk(aclk), .aresetn(aresetn),
			.t(t_op));
		persist_timer #(.W(TW)) u_rd (.aclk(aclk), .aresetn(aresetn),
			.t(t_rd));
		persist_timer #(.W(TW)) u_id (.aclk(aclk), .aresetn(aresetn),
			.t(t_id));
	end

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		logic cmd_start;
		logic cmd_reset;
		logic online;
		logic post;
		logic [N-1:0] fbk;
		logic [N-1:0] bit1;
		logic [31:0] ctrl;
		d = q;
		cmd_start = 1'b0;
		cmd_reset = 1'b0;
		post = 1'b0;
		online = 1'b0;
		sh_step = '0;
		sh_ok = '0;
		op_step = '0;
		op_ok = '0;
		rd_step = '0;
		rd_ok = '0;
		id_step = '0;
		id_ok = '0;
		fbk = q.conv ? inv_fbk : rect_fbk;
		bit1 = N'(1) << q.idx;
		ctrl = {8'h00, q.idly, q.rdly, 7'h00, q.rect_pwm};

		// Bus write side
		if (awvalid && awready) begin
			d.aw_ok = 1'b1;
			d.aw_addr = awaddr;
		end
		if (wvalid && wready) begin
			d.w_ok = 1'b1;
			d.w_data = wdata;
			d.w_strb = wstrb;
		end
		if (q.bvalid && bready) begin
			d.bvalid = 1'b0;
		end
		if (q.aw_ok && q.w_ok) begin
			d.aw_ok = 1'b0;
			d.w_ok = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = `RESP_OKAY;
			case (q.aw_addr)
				`OFF_CTRL: begin
					ctrl = merge(ctrl, q.w_data, q.w_strb);
					d.rect_pwm = ctrl[`CTRL_PWM_BIT];
					d.rdly = ctrl[`CTRL_RDLY_LSB +: 8];
					d.idly = ctrl[`CTRL_IDLY_LSB +: 8];
				end
				`OFF_CMD: begin
					cmd_start = q.w_strb[0] && q.w_data[`CMD_START_BIT];
					cmd_reset = q.w_strb[0] && q.w_data[`CMD_RESET_BIT];
				end
				default: begin
					d.bresp = `RESP_SLVERR;
				end
			endcase
		end

		// Bus read side
		if (arvalid && arready) begin
			d.rvalid = 1'b1;
			d.rresp = `RESP_OKAY;
			case (araddr)
				`OFF_CTRL: d.rdata = ctrl;
				`OFF_CMD: d.rdata = 32'h0000_0000;
				`OFF_STATUS: d.rdata = {29'h0, q.inhibit, q.conv,
					q.st != switch_diag_pkg::S_IDLE};
				`OFF_RECT_OFFLINE: d.rdata = lanes(q.r_fbk, q.r_dev,
					q.ro_open, q.ro_short);
				`OFF_RECT_ONLINE: d.rdata = lanes(q.rn_dev, q.rn_open,
					q.rn_short, q.r_gat);
				`OFF_INV_FAULTS: d.rdata = lanes(q.in_dev, q.i_gat,
					q.i_fbk, q.i_dev);
				default: begin
					d.rdata = 32'h0000_0000;
					d.rresp = `RESP_SLVERR;
				end
			endcase
		end else if (q.rvalid && rready) begin
			d.rvalid = 1'b0;
		end

		// Reset command clears the fault record before new detections
		if (cmd_reset) begin
			{d.ro_short, d.ro_open, d.r_dev, d.r_fbk, d.r_gat} = '0;
			{d.rn_short, d.rn_open, d.rn_dev} = '0;
			{d.i_dev, d.i_fbk, d.i_gat, d.in_dev} = '0;
		end

		// Offline sequencer
		d.fbk_prev = rect_fbk;
		case (q.st)
			switch_diag_pkg::S_IDLE: begin
				d.idx = '0;
				d.failed = '0;
				if (q.rect_req) begin
					d.rect_req = 1'b0;
					d.conv = 1'b0;
					d.lcnt = '0;
					d.toggled = '0;
					d.st = switch_diag_pkg::S_PASSIVE;
				end else if (q.inv_req) begin
					d.inv_req = 1'b0;
					d.conv = 1'b1;
					d.st = switch_diag_pkg::S_WAIT_PEAK;
				end
			end
			switch_diag_pkg::S_PASSIVE: begin
				d.toggled = q.toggled | (rect_fbk ^ q.fbk_prev);
				if (line_tick) begin
					d.lcnt = q.lcnt + 4'h1;
					if (q.lcnt != 4'h0 && !q.rect_pwm) begin
						d.ro_short = d.ro_short | ~d.toggled;
					end
					d.toggled = '0;
					if (q.lcnt == `PASSIVE_LINE_CYCLES) begin
						if (q.rect_pwm) begin
							d.failed = ~rect_fbk;
						end
						d.st = switch_diag_pkg::S_WAIT_PEAK;
					end
				end
			end
			switch_diag_pkg::S_WAIT_PEAK: begin
				if (!q.conv && q.rect_pwm && unsafe(q.idx, q.failed)) begin
					post = 1'b1;
				end else if (q.conv || volt_peak) begin
					d.pre = fbk[q.idx];
					d.tmr = '0;
					d.st = switch_diag_pkg::S_GATE;
				end
			end
			switch_diag_pkg::S_GATE: begin
				d.tmr = q.tmr + 16'h0001;
				if (q.tmr == 16'(`GATE_CYCLES - 1)) begin
					post = 1'b1;
					if (!q.conv && !q.rect_pwm) begin
						if (q.pre && fbk[q.idx]) begin
							d.ro_open = d.ro_open | bit1;
						end
						if (!q.pre && !fbk[q.idx]) begin
							d.ro_short = d.ro_short | bit1;
						end
					end else if (!q.pre && !fbk[q.idx]) begin
						if (q.conv) d.i_fbk = d.i_fbk | bit1;
						else d.r_fbk = d.r_fbk | bit1;
					end else if (q.pre && fbk[q.idx]) begin
						if (q.conv) d.i_gat = d.i_gat | bit1;
						else d.r_gat = d.r_gat | bit1;
					end else if (!q.pre) begin
						if (q.conv) d.i_dev = d.i_dev | bit1;
						else d.r_dev = d.r_dev | bit1;
					end
				end
			end
			default: begin
				d.st = switch_diag_pkg::S_IDLE;
			end
		endcase
		if (post) begin
			if (q.idx == IW'(N - 1)) begin
				d.st = switch_diag_pkg::S_IDLE;
				if (!q.conv) begin
					d.inhibit = line_short(q.failed | d.ro_short |
						d.r_dev);
				end
			end else begin
				d.idx = q.idx + IW'(1);
				d.st = switch_diag_pkg::S_WAIT_PEAK;
			end
		end

		// Online monitoring
		online = gating_on && q.st == switch_diag_pkg::S_IDLE;
		if (online && !q.rect_pwm && !alpha_low && !dc_discont) begin
			if (thy_sample) begin
				d.thy_all = (q.thy_seen ? q.thy_all : 1'b1) &
					!rect_fbk[thy_idx];
				d.thy_seen = 1'b1;
			end
			if (thy_fire) begin
				sh_step[thy_idx] = q.thy_seen && q.thy_all;
				sh_ok[thy_idx] = q.thy_seen && !q.thy_all;
				d.thy_seen = 1'b0;
			end
			if (thy_check) begin
				op_step[thy_idx] = rect_fbk[thy_idx];
				op_ok[thy_idx] = !rect_fbk[thy_idx];
			end
		end else begin
			d.thy_seen = 1'b0;
		end
		if (online && q.rect_pwm) begin
			if (rect_bridge_pre) d.rmal_pre = rect_mal;
			if (rect_bridge_post) begin
				rd_step = q.rmal_pre & rect_mal;
				rd_ok = ~rd_step;
			end
		end
		if (online) begin
			if (inv_bridge_pre) d.imal_pre = inv_mal;
			if (inv_bridge_post) begin
				id_step = q.imal_pre & inv_mal;
				id_ok = ~id_step;
			end
		end
		d.rn_short = d.rn_short | sh_hit;
		d.rn_open = d.rn_open | op_hit;
		d.rn_dev = d.rn_dev | rd_hit;
		d.in_dev = d.in_dev | id_hit;

		// Triggers, taken after the sequencer so none is lost
		d.cont_prev = contactor_closed;
		if (contactor_closed && !q.cont_prev) begin
			d.rect_req = 1'b1;
		end
		if (cmd_start || cmd_reset) begin
			d.rect_req = 1'b1;
			d.inv_req = 1'b1;
		end

		// Gate outputs: one offline pulse, or running gating when idle with gating_on
		d.rect_gate = '0;
		d.inv_gate = '0;
		if (d.st == switch_diag_pkg::S_GATE) begin
			if (d.conv) d.inv_gate = N'(1) << d.idx;
			else d.rect_gate = N'(1) << d.idx;
		end else if (d.st == switch_diag_pkg::S_IDLE && gating_on) begin
			d.rect_gate = rect_run_gate;
			d.inv_gate = inv_run_gate;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.inv_req <= 1'b1;
			q.rect_pwm <= `PWM_RST;
			q.rdly <= `RDLY_RST;
			q.idly <= `IDLY_RST;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign awready = !q.aw_ok && !q.bvalid;
	assign wready = !q.w_ok && !q.bvalid;
	assign bvalid = q.bvalid;
	assign bresp = q.bresp;
	assign arready = !q.rvalid;
	assign rvalid = q.rvalid;
	assign rdata = q.rdata;
	assign rresp = q.rresp;
	assign rect_gate = q.rect_gate;
	assign inv_gate = q.inv_gate;
	assign contactor_inhibit = q.inhibit;
	assign diag_busy = q.st != switch_diag_pkg::S_IDLE;
endmodule : switch_diag
`default_nettype wire

// file: switch_diag_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SWITCH_DIAG_MAP_SVH
`define SWITCH_DIAG_MAP_SVH

// Register byte offsets
`define OFF_CTRL 8'h00
`define OFF_CMD 8'h04
`define OFF_STATUS 8'h08
`define OFF_RECT_OFFLINE 8'h0c
`define OFF_RECT_ONLINE 8'h10
`define OFF_INV_FAULTS 8'h14

// Field positions
`define CTRL_PWM_BIT 0
`define CTRL_RDLY_LSB 8
`define CTRL_IDLY_LSB 16
`define CMD_START_BIT 0
`define CMD_RESET_BIT 1
`define STAT_BUSY_BIT 0
`define STAT_CONV_BIT 1
`define STAT_INHIBIT_BIT 2

// Reset values
`define RDLY_RST 8'h00
`define IDLY_RST 8'h00
`define PWM_RST 1'b0

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Timing
`define CLK_PERIOD_NS 100
`define GATE_PULSE_NS 10000
`define GATE_CYCLES ((`GATE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PASSIVE_LINE_CYCLES 4'h2
`define OPEN_FAULT_COUNT 9'h006

`endif

// file: switch_diag_pkg.sv
// Types shared by the switch diagnostics design
package switch_diag_pkg;
	typedef enum logic [1:0] {
		S_IDLE,
		S_PASSIVE,
		S_WAIT_PEAK,
		S_GATE
	} seq_state_t;
endpackage : switch_diag_pkg

// file: persist_if.sv
// Carrier between a persistence timer and its user
`timescale 1ns/1ps
`default_nettype none
interface persist_if #(parameter int W = 9);
	logic step;
	logic healthy;
	logic [W-1:0] limit;
	logic hit;
	modport core (input step, input healthy, input limit, output hit);
	modport user (output step, output healthy, output limit, input hit);
endinterface : persist_if
`default_nettype wire

// file: persist_timer.sv
// Per-switch persistence counter
`timescale 1ns/1ps
`default_nettype none
module persist_timer #(
	parameter int W = 9
) (
	input wire logic aclk,
	input wire logic aresetn,
	persist_if.core t
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic hit;
	} pt_state_t;

	pt_state_t q;
	pt_state_t d;
	logic [W-1:0] nxt;

	always_comb begin
		d = q;
		nxt = (q.cnt == {W{1'b1}}) ? q.cnt : q.cnt + W'(1);
		if (t.healthy) begin
			d.cnt = '0;
			d.hit = 1'b0;
		end else if (t.step) begin
			d.cnt = nxt;
			d.hit = (nxt >= t.limit);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign t.hit = q.hit;
endmodule : persist_timer
`default_nettype wire

// file: switch_diag_sva.sv
// Checker of bus handshakes and offline gating at the top ports
`timescale 1ns/1ps
`default_nettype none
`include "switch_diag_map.svh"
module switch_diag_sva #(
	parameter int N = 6
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [N-1:0] rect_gate,
	input wire logic [N-1:0] inv_gate,
	input wire logic gating_on,
	input wire logic contactor_closed,
	input wire logic contactor_inhibit,
	input wire logic diag_busy
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	logic [7:0] run_q;
	logic [7:0] run_d;
	logic any_gate;
	assign any_gate = |{rect_gate, inv_gate};
	always_comb run_d = any_gate ? run_q + 8'h01 : 8'h00;
	always_ff @(posedge aclk) run_q <= aresetn ? run_d : 8'h00;
	////////////////////////////////////////////////////////////////////////
	sequence s_both_taken;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence s_write_answer;
		##[1:2] bvalid;
	endsequence
	property p_write_resp;
		s_both_taken |-> s_write_answer;
	endproperty
	a_write_resp: assert property (p_write_resp) else $error("late bresp");
	property p_bresp_hold;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	a_bresp_hold: assert property (p_bresp_hold) else $error("bresp dropped");
	property p_read_resp;
		arvalid && arready |=> rvalid;
	endproperty
	a_read_resp: assert property (p_read_resp) else $error("late rvalid");
	property p_rdata_hold;
		rvalid && !rready |=> rvalid && $stable(rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("rdata dropped");
	property p_quiet_idle;
		(!diag_busy && !gating_on) [*3] |-> !any_gate;
	endproperty
	a_quiet_idle: assert property (p_quiet_idle) else $error("idle gate");
	property p_one_gated;
		diag_busy && !gating_on |-> $onehot0({rect_gate, inv_gate});
	endproperty
	a_one_gated: assert property (p_one_gated) else $error("two gated");
	property p_pulse_len;
		diag_busy && $fell(any_gate) |-> run_q == `GATE_CYCLES;
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("pulse len");
	property p_close_start;
		$rose(contactor_closed) && !diag_busy |-> ##[1:3] diag_busy;
	endproperty
	a_close_start: assert property (p_close_start) else $error("no run");
	property p_inhibit_upd;
		$changed(contactor_inhibit) |-> diag_busy || $past(diag_busy);
	endproperty
	a_inhibit_upd: assert property (p_inhibit_upd) else $error("inh");
	property p_gate_cause;
		any_gate |-> diag_busy || $past(gating_on);
	endproperty
	a_gate_cause: assert property (p_gate_cause) else $error("gate");
endmodule : switch_diag_sva
`default_nettype wire

// file: gate_driver_model.sv
// Gate driver boards answering gating with fibre feedback
`timescale 1ns/1ps
`default_nettype none
module gate_driver_model #(
	parameter int N = 6
) (
	input wire logic [N-1:0] gate,
	input wire logic [2*N-1:0] kind,
	output logic [N-1:0] fbk
);
	////////////////////////////////////////////////////////////////////////
	always_comb begin
		for (int i = 0; i < N; i++) begin
			case (kind[2*i+:2])
				2'h0: fbk[i] = ~gate[i];
				2'h1: fbk[i] = gate[i];
				2'h2: fbk[i] = 1'b0;
				default: fbk[i] = 1'b1;
			endcase
		end
	end
endmodule : gate_driver_model
`default_nettype wire

// file: power_switch_diagnostics_bench.sv
// Self-checking bench for the power switch diagnostics
`timescale 1ns/1ps
`default_nettype none
module power_switch_diagnostics_bench;
	localparam int N = 6;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, contactor_inhibit;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, got, r;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, resp;
	logic [N-1:0] rect_fbk, inv_fbk, rect_run_gate, inv_run_gate, seen;
	logic [N-1:0] rect_gate, inv_gate;
	logic gating_on, contactor_closed, line_tick, volt_peak, alpha_low;
	logic dc_discont, thy_sample, thy_fire, thy_check, diag_busy;
	logic rect_bridge_pre, rect_bridge_post, inv_bridge_pre, inv_bridge_post;
	logic [2:0] thy_idx;
	logic [6:0] stb;
	logic [2*N-1:0] rect_kind, inv_kind;
	logic [4:0] steps[$] = '{5'h0e, 5'h16, 5'h02, 5'h06, 5'h04, 5'h06, 5'h06,
		5'h06};
	bit bad[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
	int failures, checks, phase, cnt;
	assign {thy_sample, thy_fire, thy_check, inv_bridge_pre} = stb[6:3];
	assign {inv_bridge_post, rect_bridge_pre, rect_bridge_post} = stb[2:0];
	switch_diag #(.N(N)) dut (.awprot(3'h0), .arprot(3'h0), .*);
	gate_driver_model #(.N(N)) rect_drv (.gate(rect_gate), .kind(rect_kind),
		.fbk(rect_fbk));
	gate_driver_model #(.N(N)) inv_drv (.gate(inv_gate), .kind(inv_kind),
		.fbk(inv_fbk));
	////////////////////////////////////////////////////////////////////////
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		phase <= phase + 1;
		line_tick <= (phase % 40) == 0;
		volt_peak <= (phase % 15) == 0;
		seen = seen | rect_gate;
	end
	task automatic compare(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : compare
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		awaddr <= a;
		wdata <= d;
		{awvalid, wvalid, bready} <= 3'h7;
		tb = 1'b0;
		while (!tb) begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid && bready;
			resp = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) bready <= 1'b0;
		end
	endtask : wr
	task automatic rd(input logic [7:0] a);
		logic ta, tr;
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		tr = 1'b0;
		while (!tr) begin
			@(negedge aclk);
			ta = arvalid && arready;
			tr = rvalid && rready;
			got = rdata;
			resp = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			if (tr) rready <= 1'b0;
		end
		@(posedge aclk);
	endtask : rd
	task automatic strobe(input int w);
		stb <= 7'h40 >> w;
		@(posedge aclk);
		stb <= 7'h00;
		@(posedge aclk);
	endtask : strobe
	task automatic wait_idle();
		int quiet;
		quiet = 0;
		repeat (4) @(posedge aclk);
		while (quiet < 3) begin
			@(negedge aclk);
			quiet = (diag_busy === 1'b0) ? quiet + 1 : 0;
		end
		@(posedge aclk);
	endtask : wait_idle
	function automatic logic [7:0] pick(input logic [2*N-1:0] k, input int v);
		pick = 8'h00;
		for (int i = 0; i < N; i++) pick[i] = k[2*i+:2] == v;
	endfunction : pick
	function automatic logic [5:0] safe(input logic [5:0] f);
		safe = 6'h3f;
		for (int i = 0; i < 6; i++) begin
			for (int j = 0; j < 6; j++) begin
				if (f[j] && (i < 3) != (j < 3) && i % 3 != j % 3) safe[i] = 1'b0;
			end
		end
	endfunction : safe
	task automatic complete_run();
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run
	initial begin
		repeat (60000) @(posedge aclk);
		failures++;
		complete_run();
	end
	initial begin
		{failures, checks, phase, cnt} = '0;
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb, stb, thy_idx, seen} = '0;
		{rect_run_gate, inv_run_gate, gating_on, contactor_closed} = '0;
		{line_tick, volt_peak, alpha_low, dc_discont, rect_kind} = '0;
		void'($urandom(71));
		inv_kind = 12'($urandom);
		wstrb = 4'hf;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		compare(32'({awready, wready, arready, bvalid, rvalid}), 32'h1c);
		@(posedge aclk);
		wr(8'h18, 32'h0000_0001);
		compare(32'(resp), 32'h2);
		rd(8'h18);
		compare(got, 32'h0);
		compare(32'(resp), 32'h2);
		rd(8'h00);
		compare(got, 32'h0000_0000);
		wait_idle();
		rd(8'h14);
		compare(got & 32'hffffff, {8'h0, pick(inv_kind, 3), pick(inv_kind, 2),
			pick(inv_kind, 1)});
		$display("test power_up done");
		r = $urandom;
		rect_kind <= {{2{r[8]}}, {2{r[7]}}, {2{r[6]}}, r[5:0]};
		wr(8'h00, 32'h0000_0001);
		contactor_closed <= 1'b1;
		wait_idle();
		rd(8'h0c);
		compare(got & 32'hffff0000, {pick(rect_kind, 2), pick(rect_kind, 1),
			16'h0000});
		rd(8'h10);
		compare(got & 32'hff, {24'h0, pick(rect_kind, 3) & {2'h0,
			safe(6'(pick(rect_kind, 1) | pick(rect_kind, 2)))}});
		$display("test pwm_offline done");
		rect_kind <= 12'h202;
		seen = '0;
		wr(8'h04, 32'h0000_0002);
		wait_idle();
		compare(32'(contactor_inhibit), 32'h1);
		compare(32'(seen), 32'(safe(6'h11)));
		$display("test line_short done");
		{rect_kind, inv_kind} <= '0;
		wr(8'h04, 32'h0000_0002);
		wait_idle();
		wr(8'h04, 32'h0000_0001);
		wait_idle();
		for (int a = 12; a <= 20; a += 4) begin
			rd(8'(a));
			compare(got, 32'h0000_0000);
		end
		compare(32'(contactor_inhibit), 32'h0);
		$display("test healthy done");
		wr(8'h00, 32'h0002_0200);
		thy_idx <= 3'h2;
		foreach (steps[s]) begin
			{dc_discont, alpha_low, gating_on, rect_kind[5:4]} <= steps[s];
			@(posedge aclk);
			repeat (3) strobe(0);
			strobe(1);
			if (steps[s][4:2] == 3'b001) cnt = steps[s][1] ? cnt + 1 : 0;
			rd(8'h10);
			compare(32'(got[10]), 32'(cnt > 2));
		end
		thy_idx <= 3'h3;
		rect_kind[7:6] <= 2'h3;
		for (int k = 1; k <= 7; k++) begin
			strobe(2);
			rd(8'h10);
			compare(32'(got[19]), 32'(k >= 6));
		end
		$display("test thyristor_online done");
		inv_run_gate <= 6'($urandom);
		inv_kind <= 12'h555;
		cnt = 0;
		@(posedge aclk);
		foreach (bad[s]) begin
			inv_kind[3:2] <= bad[s] ? 2'h0 : 2'h1;
			repeat (2) @(posedge aclk);
			strobe(3);
			strobe(4);
			cnt = bad[s] ? cnt + 1 : 0;
			rd(8'h14);
			compare(32'(got[25]), 32'(cnt >= 2));
		end
		$display("test switch_online done");
		gating_on <= 1'b0;
		rect_kind <= 12'h038;
		wr(8'h04, 32'h0000_0001);
		wait_idle();
		rd(8'h0c);
		compare(got & 32'hffff, 32'h0000_043f);
		compare(32'(contactor_inhibit), 32'h1);
		$display("test thyristor_offline done");
		complete_run();
	end
endmodule : power_switch_diagnostics_bench
bind switch_diag switch_diag_sva #(.N(N)) chk (.*);
`default_nettype wire
